// ==== lscd_decoder.sv ====
// Operation
// - sample serial_in on rising link clock while select low, MSB first
// - select high ignores clock edges and resets the bit counter
// - falling select starts a transmission; host lowers select first
// - command/data line sampled with eighth bit; low command, high data
// - select still low after a byte means next edge is bit 7
// - reset aborts byte, writes nothing, clears settings; next bit is 7
// - after each data write advance address per direction setting
// - instructions in any order; all-zero command is no operation
// - 00100 PVH loads power down, direction, page; valid in both pages
// - page 0 runs display, bank, column; page 1 temp, bias, voltage
// - page-0 00001m0n sets display mode from m and n
// - page-0 01000yyy sets bank address directly
// - page-0 bit 7 set loads column address from low seven bits
// - page-1 000001tt stores temperature coefficient select
// - page-1 00010bbb stores bias select
// - page-1 bit 7 set stores operating voltage code
// - voltage code zero keeps charge pump off
// - reset sets power down, clears every other setting
// - power down blanks display and stops oscillator, link keeps working
// - direction 0 horizontal stepping, 1 vertical stepping
// - vertical: bank advances, after bank 5 wraps and column advances
// - horizontal: column advances, wraps after 83, bank advances
// - RAM is six banks of 84 bytes, one byte per column
//
// Top of the serial command decoder. The link pins arrive asynchronously
// and are sampled by i_clk, which must run well above the link bit rate.
// Link edges are found from synchronised copies, so each one is acted on
// about three i_clk cycles late. The host must therefore keep each link
// clock phase at least three i_clk cycles long and lower the select at
// least three cycles before the first rising edge.
// The reset pin passes the same synchroniser and must stay low for at
// least three cycles to be seen.
`timescale 1ns/10ps
module lscd_decoder (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Link pins from the host
  input wire logic i_serial_in,
  input wire logic i_serial_clock_in,
  input wire logic i_chip_select_n,
  input wire logic i_cmd_data_select,
  input wire logic i_reset_n_pin,
  // Display RAM read port for the scan logic
  input wire logic [8:0] i_scan_addr,
  output logic [7:0] o_scan_data,
  // Settings
  output logic o_power_down_bit,
  output logic o_addr_direction_bit,
  output logic o_instr_page_bit,
  output logic [1:0] o_display_mode,
  output logic [6:0] o_column_addr,
  output logic [2:0] o_bank_addr,
  output logic [1:0] o_temp_coeff_sel,
  output logic [2:0] o_bias_sel,
  output logic [6:0] o_op_voltage_code,
  // Derived controls
  output logic o_charge_pump_en,
  output logic o_display_on,
  output logic o_osc_en,
  // Byte strobe for observation
  output logic o_byte_done
);
  // Two-stage synchronisers for every link pin
  // Only the second stage is read; the first may settle late
  // Select resets high so no frame seems to start out of reset
  logic [1:0] sync_sdi;
  logic [1:0] sync_sck;
  logic [1:0] sync_cs;
  logic [1:0] sync_dc;
  logic [1:0] sync_rst;
  logic sck_prev;
  logic cs_prev;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_sdi <= 2'h0;
      sync_sck <= 2'h0;
      sync_cs <= 2'h3;
      sync_dc <= 2'h0;
      sync_rst <= 2'h0;
    end else begin
      sync_sdi <= {sync_sdi[0], i_serial_in};
      sync_sck <= {sync_sck[0], i_serial_clock_in};
      sync_cs <= {sync_cs[0], i_chip_select_n};
      sync_dc <= {sync_dc[0], i_cmd_data_select};
      sync_rst <= {sync_rst[0], i_reset_n_pin};
    end
  end

  // Edge history, read only from the second synchroniser stage
  // Select history marks the first cycle of a frame
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sck_prev <= 1'h0;
      cs_prev <= 1'h1;
    end else begin
      sck_prev <= sync_sck[1];
      cs_prev <= sync_cs[1];
    end
  end

  logic sck_rise;
  logic cs_low;
  logic pin_rst;
  assign sck_rise = sync_sck[1] & ~sck_prev;
  assign cs_low = ~sync_cs[1];
  assign pin_rst = ~sync_rst[1];

  // Receiver: idle while select high, shifting once it falls
  // A link edge in the cycle the select falls is lost; hence the set-up
  lscd_pkg::lscd_rx_e state;
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic byte_strobe;
  logic [7:0] byte_val;
  logic byte_is_data;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= lscd_pkg::LSCD_IDLE;
    end else if (pin_rst || !cs_low) begin
      state <= lscd_pkg::LSCD_IDLE;
    end else begin
      case (state)
        lscd_pkg::LSCD_IDLE: begin
          if (cs_prev) begin
            state <= lscd_pkg::LSCD_SHIFT;
          end else begin
            state <= lscd_pkg::LSCD_SHIFT;
          end
        end
        lscd_pkg::LSCD_SHIFT: state <= lscd_pkg::LSCD_SHIFT;
        default: state <= lscd_pkg::LSCD_IDLE;
      endcase
    end
  end

  // Bit counter counts down from 7; a partial byte is dropped on abort
  // Counting down makes zero the last bit, whatever the frame length
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bit_cnt <= lscd_pkg::BIT_LAST;
      shift <= 7'h00;
    end else if (pin_rst || !cs_low || state == lscd_pkg::LSCD_IDLE) begin
      bit_cnt <= lscd_pkg::BIT_LAST;
    end else if (sck_rise) begin
      shift <= {shift[5:0], sync_sdi[1]};
      bit_cnt <= bit_cnt - 3'h1;
    end
  end

  // Completed byte; command/data read with the eighth bit
  // The strobe lasts one cycle; the decode below acts only in that cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      byte_strobe <= 1'h0;
      byte_val <= 8'h00;
      byte_is_data <= 1'h0;
    end else begin
      byte_strobe <= 1'h0;
      if (!pin_rst && cs_low && state == lscd_pkg::LSCD_SHIFT &&
          sck_rise && bit_cnt == 3'h0) begin
        byte_strobe <= 1'h1;
        byte_val <= {shift, sync_sdi[1]};
        byte_is_data <= sync_dc[1];
      end
    end
  end

  assign o_byte_done = byte_strobe;

  // Command field decode
  // Page gating uses the page bit held before this byte arrived
  logic is_cmd;
  logic cmd_func;
  logic cmd_disp;
  logic cmd_bank;
  logic cmd_col;
  logic cmd_temp;
  logic cmd_bias;
  logic cmd_vop;
  assign is_cmd = byte_strobe & ~byte_is_data;
  // All-zero and reserved codes match none of these and act as no-ops
  assign cmd_func = is_cmd && byte_val[7:3] == lscd_pkg::CMD_FUNC_SET;
  assign cmd_disp = is_cmd && !o_instr_page_bit && byte_val[1] == 1'h0 &&
                    byte_val[7:3] == lscd_pkg::CMD_DISP_CTRL;
  assign cmd_bank = is_cmd && !o_instr_page_bit &&
                    byte_val[7:3] == lscd_pkg::CMD_BANK_SET;
  assign cmd_col = is_cmd && !o_instr_page_bit && byte_val[7];
  assign cmd_temp = is_cmd && o_instr_page_bit &&
                    byte_val[7:2] == lscd_pkg::CMD_TEMP_CTRL;
  assign cmd_bias = is_cmd && o_instr_page_bit &&
                    byte_val[7:3] == lscd_pkg::CMD_BIAS_SET;
  assign cmd_vop = is_cmd && o_instr_page_bit && byte_val[7];

  // Function set and display/voltage settings
  // The pin reset wins over a command that lands in the same cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_power_down_bit <= lscd_pkg::RST_POWER_DOWN;
      o_addr_direction_bit <= 1'h0;
      o_instr_page_bit <= 1'h0;
      o_display_mode <= lscd_pkg::RST_DISP_MODE;
      o_temp_coeff_sel <= lscd_pkg::RST_TEMP_COEFF;
      o_bias_sel <= lscd_pkg::RST_BIAS;
      o_op_voltage_code <= lscd_pkg::RST_OP_VOLT;
    end else if (pin_rst) begin
      o_power_down_bit <= lscd_pkg::RST_POWER_DOWN;
      o_addr_direction_bit <= 1'h0;
      o_instr_page_bit <= 1'h0;
      o_display_mode <= lscd_pkg::RST_DISP_MODE;
      o_temp_coeff_sel <= lscd_pkg::RST_TEMP_COEFF;
      o_bias_sel <= lscd_pkg::RST_BIAS;
      o_op_voltage_code <= lscd_pkg::RST_OP_VOLT;
    end else begin
      if (cmd_func) begin
        o_power_down_bit <= byte_val[2];
        o_addr_direction_bit <= byte_val[1];
        o_instr_page_bit <= byte_val[0];
      end
      if (cmd_disp) begin
        o_display_mode <= {byte_val[2], byte_val[0]};
      end
      if (cmd_temp) begin
        o_temp_coeff_sel <= byte_val[1:0];
      end
      if (cmd_bias) begin
        o_bias_sel <= byte_val[2:0];
      end
      if (cmd_vop) begin
        o_op_voltage_code <= byte_val[6:0];
      end
    end
  end

  // Data write into the RAM at the current address
  logic ram_we;
  logic [8:0] ram_waddr;
  assign ram_we = byte_strobe & byte_is_data & ~pin_rst;
  assign ram_waddr = 9'(o_bank_addr * lscd_pkg::COLS + o_column_addr);

  // Address counter: direct loads and auto-advance after data bytes
  // A byte is command or data, so a load and an advance never meet
  // Out-of-range loads still wrap at the ends, since >= is used
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_column_addr <= 7'h00;
      o_bank_addr <= 3'h0;
    end else if (pin_rst) begin
      o_column_addr <= 7'h00;
      o_bank_addr <= 3'h0;
    end else if (cmd_bank) begin
      o_bank_addr <= byte_val[2:0];
    end else if (cmd_col) begin
      o_column_addr <= byte_val[6:0];
    end else if (ram_we) begin
      if (o_addr_direction_bit) begin
        if (o_bank_addr >= lscd_pkg::BANK_LAST) begin
          o_bank_addr <= 3'h0;
          o_column_addr <= (o_column_addr >= lscd_pkg::COL_LAST) ?
                           7'h00 : o_column_addr + 7'h01;
        end else begin
          o_bank_addr <= o_bank_addr + 3'h1;
        end
      end else begin
        if (o_column_addr >= lscd_pkg::COL_LAST) begin
          o_column_addr <= 7'h00;
          o_bank_addr <= (o_bank_addr >= lscd_pkg::BANK_LAST) ?
                         3'h0 : o_bank_addr + 3'h1;
        end else begin
          o_column_addr <= o_column_addr + 7'h01;
        end
      end
    end
  end

  // Power and display enables follow the settings
  // The pump is held off in power-down too, whatever the code
  assign o_charge_pump_en = (o_op_voltage_code != 7'h00) &
                            ~o_power_down_bit;
  assign o_display_on = ~o_power_down_bit;
  assign o_osc_en = ~o_power_down_bit;

  // Display RAM; not cleared by reset
  // Scan reads have one cycle of latency from i_scan_addr
  lscd_ram #(
    .DEPTH(lscd_pkg::RAM_DEPTH),
    .AW(lscd_pkg::RAM_AW)
  ) u_ram (
    .i_clk(i_clk),
    .i_we(ram_we),
    .i_waddr(ram_waddr),
    .i_wdata(byte_val),
    .i_raddr(i_scan_addr),
    .o_rdata(o_scan_data)
  );
endmodule // lscd_decoder

// ==== lscd_pkg.sv ====
// Package for the serial command decoder of a dot-matrix display controller.
// Assumes a single system clock; all uses are written lscd_pkg::name.
package lscd_pkg;
  // Display RAM geometry
  localparam int BANKS = 6;
  localparam int COLS = 84;
  localparam logic [2:0] BANK_LAST = 3'h5;
  localparam logic [6:0] COL_LAST = 7'h53;
  localparam int RAM_DEPTH = BANKS * COLS;
  localparam int RAM_AW = 9;
  // Values after reset
  localparam logic RST_POWER_DOWN = 1'h1;
  localparam logic [1:0] RST_DISP_MODE = 2'h0;
  localparam logic [1:0] RST_TEMP_COEFF = 2'h0;
  localparam logic [2:0] RST_BIAS = 3'h0;
  localparam logic [6:0] RST_OP_VOLT = 7'h00;
  // Serial bit count
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Command patterns (upper bits compared)
  localparam logic [4:0] CMD_FUNC_SET = 5'h04;
  localparam logic [4:0] CMD_DISP_CTRL = 5'h01;
  localparam logic [4:0] CMD_BANK_SET = 5'h08;
  localparam logic [5:0] CMD_TEMP_CTRL = 6'h01;
  localparam logic [4:0] CMD_BIAS_SET = 5'h02;
  // Receiver states
  typedef enum logic [0:0] {LSCD_IDLE, LSCD_SHIFT} lscd_rx_e;
endpackage

// ==== lscd_ram.sv ====
// Display RAM: six banks of 84 bytes, one write port, registered read port.
// Assumes writes and reads arrive on the same system clock.
`timescale 1ns/10ps
module lscd_ram #(
  parameter int DEPTH = 504,
  parameter int AW = 9
) (
  // Clock
  input wire logic i_clk,
  // Write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // Read port
  input wire logic [AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [DEPTH];

  // Contents have no reset; software must load them after power-on
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // lscd_ram

// ==== lscd_checker.sv ====
// Checker for the serial command decoder, bound to lscd_decoder.
// Assumes only the top ports and the single i_clk domain.
`timescale 1ns/10ps
module lscd_checker (
  // Clock and resets
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_reset_n_pin,
  // Settings and controls
  input wire logic o_power_down_bit,
  input wire logic o_addr_direction_bit,
  input wire logic o_instr_page_bit,
  input wire logic [1:0] o_display_mode,
  input wire logic [6:0] o_column_addr,
  input wire logic [2:0] o_bank_addr,
  input wire logic [2:0] o_bias_sel,
  input wire logic [6:0] o_op_voltage_code,
  input wire logic o_charge_pump_en,
  input wire logic o_display_on,
  input wire logic o_osc_en,
  input wire logic o_byte_done
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic [4:0] pin_hist;
  logic calm;
  // Settings may jump for a few cycles after the pin reset, so mask that
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_hist <= 5'h1F;
    end else begin
      pin_hist <= {pin_hist[3:0], i_reset_n_pin};
    end
  end
  assign calm = &pin_hist & i_reset_n_pin;
  pump_rule_a: assert property (o_charge_pump_en ==
    (o_op_voltage_code != 7'h00 && !o_power_down_bit))
    else $error("charge pump enable wrong");
  display_off_a: assert property (o_display_on == !o_power_down_bit)
    else $error("display enable wrong");
  osc_stop_a: assert property (o_osc_en == !o_power_down_bit)
    else $error("oscillator enable wrong");
  strobe_width_a: assert property (o_byte_done |=> !o_byte_done)
    else $error("byte strobe too long");
  bias_page_a: assert property ($changed(o_bias_sel) && calm
    |-> $past(o_byte_done) && $past(o_instr_page_bit))
    else $error("bias changed outside a page 1 command");
  mode_page_a: assert property ($changed(o_display_mode) && calm
    |-> $past(o_byte_done) && !$past(o_instr_page_bit))
    else $error("display mode changed outside a page 0 command");
  sys_reset_a: assert property ($rose(i_resetn) |-> o_power_down_bit
    && o_bias_sel == 3'h0 && o_column_addr == 7'h00 && !o_instr_page_bit)
    else $error("settings not cleared by reset");
  pin_reset_a: assert property ($fell(i_reset_n_pin) |-> ##[1:4]
    (o_power_down_bit && o_op_voltage_code == 7'h00 && o_bank_addr == 3'h0))
    else $error("reset pin did not clear settings");
  h_wrap_a: assert property ($past(o_byte_done) && calm &&
    !$past(o_addr_direction_bit) && $changed(o_bank_addr) &&
    $changed(o_column_addr) |-> $past(o_column_addr) == lscd_pkg::COL_LAST
    && o_column_addr == 7'h00)
    else $error("horizontal wrap wrong");
  v_wrap_a: assert property ($past(o_byte_done) && calm &&
    $past(o_addr_direction_bit) && $changed(o_bank_addr) &&
    $changed(o_column_addr) |-> $past(o_bank_addr) == lscd_pkg::BANK_LAST
    && o_bank_addr == 3'h0)
    else $error("vertical wrap wrong");
  cover property (o_byte_done && o_instr_page_bit);
  cover property ($changed(o_display_mode));
  cover property ($fell(i_reset_n_pin));
endmodule // lscd_checker

bind lscd_decoder lscd_checker chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_reset_n_pin(i_reset_n_pin),
  .o_power_down_bit(o_power_down_bit),
  .o_addr_direction_bit(o_addr_direction_bit),
  .o_instr_page_bit(o_instr_page_bit), .o_display_mode(o_display_mode),
  .o_column_addr(o_column_addr), .o_bank_addr(o_bank_addr),
  .o_bias_sel(o_bias_sel), .o_op_voltage_code(o_op_voltage_code),
  .o_charge_pump_en(o_charge_pump_en), .o_display_on(o_display_on),
  .o_osc_en(o_osc_en), .o_byte_done(o_byte_done)
);

// ==== lscd_host.sv ====
// Host model driving the write-only link, one bit per 400 ns link period.
// Assumes i_clk at 50 ns; pins change at its falling edge.
`timescale 1ns/10ps
module lscd_host (
  // Clock
  input wire logic i_clk,
  // Link pins
  output logic o_serial_in,
  output logic o_serial_clock_in,
  output logic o_chip_select_n,
  output logic o_cmd_data_select
);
  // Link clock stands still low between frames
  initial begin
    o_serial_in = 1'h0;
    o_serial_clock_in = 1'h0;
    o_chip_select_n = 1'h1;
    o_cmd_data_select = 1'h0;
  end
  // Select falls well ahead of the first link edge
  task automatic start();
    @(negedge i_clk) o_chip_select_n <= 1'h0;
    repeat (4) @(negedge i_clk);
  endtask
  // Released data line shows the inverse of its last value
  task automatic stop();
    @(negedge i_clk) o_chip_select_n <= 1'h1;
    o_serial_in <= ~o_serial_in;
    // Select stays high long enough for the device to see the frame end
    repeat (4) @(negedge i_clk);
  endtask
  // Shift n bits MSB first; the mode level is held across the byte
  task automatic shift(input logic [7:0] b, input int n, input logic dc);
    for (int i = 7; i > 7 - n; i--) begin
      o_serial_in <= b[i];
      o_cmd_data_select <= dc;
      repeat (4) @(negedge i_clk);
      o_serial_clock_in <= 1'h1;
      repeat (4) @(negedge i_clk);
      o_serial_clock_in <= 1'h0;
    end
  endtask
endmodule // lscd_host

// ==== test_lcd_serial_command_decoder.sv ====
// Testbench for the serial command decoder with a host link model.
// Assumes a 20 MHz system clock; each byte takes eight 400 ns periods.
`timescale 1ns/10ps
module test_lcd_serial_command_decoder;
  logic clk, rstn, pin_n, serial_in, sclk, cs_n, dc;
  logic pd, vdir, page, pump, don, osc, done;
  logic [8:0] scan;
  logic [7:0] rdata;
  logic [1:0] mode, tc;
  logic [6:0] col, op_voltage_code;
  logic [2:0] bank, bias;
  int bad_count, checks, nbytes, cycles;
  lscd_decoder uut (.i_clk(clk), .i_resetn(rstn), .i_serial_in(serial_in),
    .i_serial_clock_in(sclk), .i_chip_select_n(cs_n),
    .i_cmd_data_select(dc), .i_reset_n_pin(pin_n), .i_scan_addr(scan),
    .o_scan_data(rdata), .o_power_down_bit(pd), .o_addr_direction_bit(vdir),
    .o_instr_page_bit(page), .o_display_mode(mode), .o_column_addr(col),
    .o_bank_addr(bank), .o_temp_coeff_sel(tc), .o_bias_sel(bias),
    .o_op_voltage_code(op_voltage_code), .o_charge_pump_en(pump), .o_display_on(don),
    .o_osc_en(osc), .o_byte_done(done));
  lscd_host host (.i_clk(clk), .o_serial_in(serial_in), .o_serial_clock_in(sclk),
    .o_chip_select_n(cs_n), .o_cmd_data_select(dc));
  // System clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // Count bytes and cut a hang short
  always @(posedge clk) begin
    nbytes <= nbytes + int'(done);
    cycles <= cycles + 1;
    if (cycles == 45000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic check_eq(input logic [7:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  // One byte, then let the setting land before judging
  task automatic xb(input logic [7:0] b, input logic d);
    int n0;
    n0 = nbytes;
    host.shift(b, 8, d);
    repeat (4) @(negedge clk);
    check_eq(8'(nbytes - n0), 8'h01, "byte count");
  endtask
  task automatic t_reset();
    check_eq({pd, vdir, page, mode, bias}, 8'h80, "reset flags");
    check_eq({4'h0, |{col, bank, tc, op_voltage_code}, pump, don, osc}, 8'h00,
      "reset fields");
    $display("reset test done");
  endtask
  task automatic t_page1();
    host.start();
    xb(8'h21, 1'h0);
    check_eq({3'h0, don, osc, pd, vdir, page}, 8'h19, "function set");
    for (int i = 0; i < 4; i++) begin
      xb(8'h04 | 8'(i), 1'h0);
      check_eq({6'h0, tc}, 8'(i), "temp coeff");
    end
    for (int i = 0; i < 8; i++) begin
      xb(8'h10 | 8'(i), 1'h0);
      check_eq({5'h0, bias}, 8'(i), "bias");
    end
    xb(8'hBF, 1'h0);
    check_eq({op_voltage_code, pump}, 8'h7F, "voltage on");
    xb(8'h80, 1'h0);
    check_eq({op_voltage_code, pump}, 8'h00, "pump off");
    xb(8'h0D, 1'h0);
    xb(8'h43, 1'h0);
    check_eq({mode, bias, bank}, 8'h38, "wrong page ignored");
    host.stop();
    $display("page 1 test done");
  endtask
  task automatic t_page0();
    host.start();
    xb(8'h20, 1'h0);
    for (int i = 0; i < 4; i++) begin
      xb(8'h08 | {5'h0, i[1], 1'h0, i[0]}, 1'h0);
      check_eq({6'h0, mode}, 8'(i), "display mode");
    end
    xb(8'h04, 1'h0);
    xb(8'h00, 1'h0);
    check_eq({pd, vdir, page, mode, tc}, 8'h0F, "no operation");
    xb(8'h45, 1'h0);
    xb(8'hD3, 1'h0);
    check_eq({col, 1'h0}, 8'hA6, "column");
    check_eq({5'h0, bank}, 8'h05, "bank");
    xb(8'hA5, 1'h1);
    scan = 9'h1F7;
    check_eq({col, bank[0]}, 8'h00, "horizontal wrap");
    xb(8'h22, 1'h0);
    xb(8'h8A, 1'h0);
    check_eq(rdata, 8'hA5, "ram byte");
    xb(8'h45, 1'h0);
    xb(8'h3C, 1'h1);
    scan = 9'h1AE;
    check_eq({col, bank[0]}, 8'h16, "vertical step");
    @(negedge clk);
    check_eq(rdata, 8'h3C, "ram column");
    host.stop();
    $display("page 0 test done");
  endtask
  // Zero every RAM byte before the power-down command of the next test
  task automatic t_blank();
    int n0;
    n0 = nbytes;
    host.start();
    for (int i = 0; i < lscd_pkg::RAM_DEPTH; i++) begin
      host.shift(8'h00, 8, 1'h1);
    end
    repeat (4) @(negedge clk);
    check_eq(8'(nbytes - n0), 8'(lscd_pkg::RAM_DEPTH), "fill count");
    check_eq({1'h0, col}, 8'h0B, "column after full wrap");
    check_eq({5'h0, bank}, 8'h00, "bank after full wrap");
    scan = 9'h1AE;
    @(negedge clk);
    check_eq(rdata, 8'h00, "ram cleared");
    scan = 9'h1F7;
    @(negedge clk);
    check_eq(rdata, 8'h00, "last byte cleared");
    host.stop();
    $display("blank test done");
  endtask
  task automatic t_partial();
    host.start();
    host.shift(8'hFF, 3, 1'h0);
    host.stop();
    host.start();
    xb(8'h24, 1'h0);
    check_eq({5'h0, pd, vdir, page}, 8'h04, "partial dropped");
    host.stop();
    $display("partial byte test done");
  endtask
  task automatic t_pin();
    int n0;
    host.start();
    xb(8'h21, 1'h0);
    xb(8'h13, 1'h0);
    n0 = nbytes;
    host.shift(8'hFF, 4, 1'h0);
    pin_n = 1'h0;
    repeat (4) @(negedge clk);
    pin_n = 1'h1;
    repeat (4) @(negedge clk);
    check_eq({pd, page, bias, 3'(nbytes - n0)}, 8'h80, "pin reset");
    xb(8'h45, 1'h0);
    check_eq({5'h0, bank}, 8'h05, "bit 7 after reset");
    host.stop();
    $display("reset pin test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial begin
    rstn = 1'h0;
    pin_n = 1'h0;
    scan = 9'h000;
    bad_count = 0;
    checks = 0;
    nbytes = 0;
    cycles = 0;
    repeat (4) @(negedge clk);
    rstn = 1'h1;
    pin_n = 1'h1;
    @(negedge clk);
    t_reset();
    t_page1();
    t_page0();
    t_blank();
    t_partial();
    t_pin();
    tally_and_finish();
  end
endmodule // test_lcd_serial_command_decoder
